/* File: sram_device.sv */
// Pipelined single-cycle-deselect burst memory, device end
//
// Functional notes
// R1 - All synchronous inputs captured on rising clock
// R2 - Array is 128Kx18, 64Kx32 or 64Kx36
// R3 - Two-bit counter supplies low burst address
// R4 - Selected only when all three enables asserted
// R5 - Output enable and snooze act without clock
// R6 - Mode input picks interleaved or linear order
// R7 - Either address strobe loads a new address
// R8 - Burst steps only when advance is low
// R9 - Writes cover one to all byte lanes
// R10 - Narrow shape: enables a,b gate lanes a,b
// R11 - Wide shape: four enables gate lanes a-d
// R12 - Global write low writes every lane
// R13 - Parity only on 18 and 36 bit shapes
// R14 - Address and write controls held, self-timed write
// R15 - Deselect after read floats outputs next edge
// R16 - Snooze asserted enters reduced-power standby
// R17 - Expansion enables sampled only on address load
// R18 - Primary enable qualifies processor address strobe
// R19 - Byte writes need permit low; enable low writes
// R20 - Global write ignores permit and byte enables
// R21 - Linear adds beat, interleaved XORs beat
// R22 - Read data valid after the following edge
`timescale 1ns/10ps
`include "sram_port_defines.svh"
module sram_device #(
   parameter sram_port_pkg::word_cfg_t CFG = sram_port_pkg::CFG_X36
) (
   input  wire logic   ref_clk,
   input  wire logic   resetn,
   sram_bus_if.device  bus,
   output logic        standby
);
   import sram_port_pkg::*;

   // ------------------------------------------------------------------------
   // Shape of the array
   // ------------------------------------------------------------------------
   localparam int ADDR_W  = (CFG == CFG_X18) ? `ADDR_W_X18 : `ADDR_W_WIDE;
   localparam int LANES   = (CFG == CFG_X18) ? `LANES_X18 : `LANES_WIDE;
   localparam int DW      = LANES * `LANE_BITS;
   localparam int DEPTH   = 1 << ADDR_W;
   localparam bit HAS_PAR = (CFG != CFG_X32);
   localparam int LO      = `BURST_LO_BITS;

   if ($bits(bus.addr) != ADDR_W || $bits(bus.dev_parity) != LANES) begin
      $error("sram_device: bus widths do not match the array shape");
   end

   // ------------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------------
   logic [DW-1:0]    rd_word; // R2
   logic [LANES-1:0] rd_word_par;

   // ------------------------------------------------------------------------
   // Snooze synchroniser and power state
   // ------------------------------------------------------------------------
   logic [`SYNC_STAGES-1:0] snz_sync_reg;
   logic [`SYNC_STAGES-1:0] snz_sync_next;
   pwr_state_t              pwr_reg;
   pwr_state_t              pwr_next;

   always_comb begin
      snz_sync_next = {snz_sync_reg[`SYNC_STAGES-2:0], bus.snooze_in};
      pwr_next      = pwr_reg;
      case (pwr_reg)
         PWR_ACTIVE: begin
            if (snz_sync_reg[1] && snz_sync_reg[2]) begin
               pwr_next = PWR_STANDBY; // R16
            end
         end
         PWR_STANDBY: begin
            if (!snz_sync_reg[1] && !snz_sync_reg[2]) begin
               pwr_next = PWR_ACTIVE;
            end
         end
         default: pwr_next = PWR_ACTIVE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         snz_sync_reg <= '0;
         pwr_reg      <= PWR_ACTIVE;
      end else begin
         snz_sync_reg <= snz_sync_next;
         pwr_reg      <= pwr_next;
      end
   end

   assign standby = (pwr_reg == PWR_STANDBY);

   // ------------------------------------------------------------------------
   // Address load, select and burst stepping
   // ------------------------------------------------------------------------
   logic          load_proc;
   logic          load;
   logic          chips_ok;
   logic          active;
   logic          advance;
   logic [LO-1:0] cur_lo;
   logic          sel_reg;
   logic          sel_next;

   always_comb begin
      active    = (pwr_reg == PWR_ACTIVE);
      load_proc = !bus.addr_strobe_proc_n && !bus.chip_sel_n; // R18
      load      = load_proc || !bus.addr_strobe_ctrl_n; // R7
      chips_ok  = !bus.chip_sel_n && bus.chip_sel_expand_hi
                  && !bus.chip_sel_expand_n; // R4
      advance   = !load && !bus.burst_advance_n && sel_reg; // R8
      sel_next  = sel_reg;
      if (!active) begin
         sel_next = 1'b0; // R16
      end else if (load) begin
         sel_next = chips_ok; // R17
      end
   end

   burst_addr_gen u_burst (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .load     (load),
      .advance  (advance),
      .linear   (bus.burst_linear),
      .start_lo (bus.addr[LO-1:0]),
      .cur_lo   (cur_lo)
   );

   // ------------------------------------------------------------------------
   // Registered access: address, write controls and write data
   // ------------------------------------------------------------------------
   logic              acc_valid_reg;
   logic              acc_valid_next;
   logic              acc_wr_reg;
   logic              acc_wr_next;
   logic [ADDR_W-1:0] acc_addr_reg;
   logic [ADDR_W-1:0] acc_addr_next;
   logic [LANES-1:0]  acc_mask_reg;
   logic [LANES-1:0]  acc_mask_next;
   logic [DW-1:0]     acc_data_reg;
   logic [DW-1:0]     acc_data_next;
   logic [LANES-1:0]  acc_par_reg;
   logic [LANES-1:0]  acc_par_next;

   always_comb begin
      acc_valid_next = sel_next; // R1
      acc_mask_next  = '0;
      if (load_proc) begin
         acc_mask_next = '0; // processor strobe cycle is always a read
      end else if (!bus.full_word_write_n) begin
         acc_mask_next = '1; // R12 R20
      end else if (!bus.byte_write_permit_n) begin
         acc_mask_next = ~bus.lane_write_en_n; // R9 R19
      end
      acc_wr_next   = acc_valid_next && (acc_mask_next != '0);
      acc_addr_next = acc_addr_reg;
      if (load) begin
         acc_addr_next = {bus.addr[ADDR_W-1:LO], cur_lo}; // R7
      end else begin
         acc_addr_next = {acc_addr_reg[ADDR_W-1:LO], cur_lo}; // R3
      end
      acc_data_next = bus.data_lanes; // R1
      acc_par_next  = HAS_PAR ? bus.parity_lanes : '0; // R13
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sel_reg       <= 1'b0;
         acc_valid_reg <= 1'b0;
         acc_wr_reg    <= 1'b0;
         acc_addr_reg  <= '0;
         acc_mask_reg  <= '0;
         acc_data_reg  <= '0;
         acc_par_reg   <= '0;
      end else begin
         sel_reg       <= sel_next;
         acc_valid_reg <= acc_valid_next;
         acc_wr_reg    <= acc_wr_next;
         acc_addr_reg  <= acc_addr_next;
         acc_mask_reg  <= acc_mask_next;
         acc_data_reg  <= acc_data_next;
         acc_par_reg   <= acc_par_next;
      end
   end

   // ------------------------------------------------------------------------
   // Self-timed array write, one lane per loop pass
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      // Each lane owns its storage, so every array has a single writer
      logic [`LANE_BITS-1:0] lane_mem [DEPTH];
      logic                  par_mem  [DEPTH];

      always_ff @(posedge ref_clk) begin
         if (acc_wr_reg && acc_mask_reg[i]) begin // R10 R11 R14
            lane_mem[acc_addr_reg] <=
               acc_data_reg[i*`LANE_BITS +: `LANE_BITS];
            par_mem[acc_addr_reg]  <= acc_par_reg[i]; // R13
         end
      end

      assign rd_word[i*`LANE_BITS +: `LANE_BITS] = lane_mem[acc_addr_reg];
      assign rd_word_par[i] = par_mem[acc_addr_reg];
   end

   // ------------------------------------------------------------------------
   // Read pipeline and output drive
   // ------------------------------------------------------------------------
   logic [DW-1:0]    q_data_reg;
   logic [DW-1:0]    q_data_next;
   logic [LANES-1:0] q_par_reg;
   logic [LANES-1:0] q_par_next;
   logic             q_valid_reg;
   logic             q_valid_next;

   always_comb begin
      q_valid_next = acc_valid_reg && !acc_wr_reg; // R15 R22
      q_data_next  = q_data_reg;
      q_par_next   = q_par_reg;
      if (q_valid_next) begin
         q_data_next = rd_word; // R22
         q_par_next  = HAS_PAR ? rd_word_par : '0; // R13
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q_valid_reg <= 1'b0;
         q_data_reg  <= '0;
         q_par_reg   <= '0;
      end else begin
         q_valid_reg <= q_valid_next;
         q_data_reg  <= q_data_next;
         q_par_reg   <= q_par_next;
      end
   end

   assign bus.dev_data   = q_data_reg;
   assign bus.dev_parity = q_par_reg;
   // Output enable and snooze gate the drivers without the clock
   assign bus.dev_drive  = q_valid_reg && !bus.out_enable_n
                           && !bus.snooze_in; // R5 R16
endmodule // sram_device

/* File: sram_port_defines.svh */
// Constants shared by both ends of the burst memory port
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// --------------------------------------------------------------------------
// Array shapes
// --------------------------------------------------------------------------
`define ADDR_W_X18    17
`define ADDR_W_WIDE   16
`define LANES_X18     2
`define LANES_WIDE    4
`define LANE_BITS     8

// --------------------------------------------------------------------------
// Burst and pipeline
// --------------------------------------------------------------------------
`define BURST_LO_BITS 2
`define BURST_BEATS   4
`define READ_LATENCY  2
`define SYNC_STAGES   3

`endif

/* File: sram_port_pkg.sv */
// Types shared by both ends of the burst memory port
package sram_port_pkg;

   // -----------------------------------------------------------------------
   // Array organisation
   // -----------------------------------------------------------------------
   typedef enum {CFG_X18, CFG_X32, CFG_X36} word_cfg_t;

   // -----------------------------------------------------------------------
   // State machines
   // -----------------------------------------------------------------------
   typedef enum {PWR_ACTIVE, PWR_STANDBY} pwr_state_t;
   typedef enum {M_IDLE, M_BURST, M_DESEL} mst_state_t;

   // -----------------------------------------------------------------------
   // Control pins driven by the bus master
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic addr_strobe_proc_n;
      logic addr_strobe_ctrl_n;
      logic burst_advance_n;
      logic chip_sel_n;
      logic chip_sel_expand_hi;
      logic chip_sel_expand_n;
      logic byte_write_permit_n;
      logic full_word_write_n;
      logic out_enable_n;
   } ctrl_pins_t;

endpackage

/* File: sram_bus_if.sv */
// Pin-level carrier between the memory device and its bus master
`timescale 1ns/10ps
interface sram_bus_if #(
   parameter int ADDR_W = 16,
   parameter int LANES  = 4
);
   logic [ADDR_W-1:0]  addr;
   logic               addr_strobe_proc_n;
   logic               addr_strobe_ctrl_n;
   logic               burst_advance_n;
   logic               chip_sel_n;
   logic               chip_sel_expand_hi;
   logic               chip_sel_expand_n;
   logic [LANES-1:0]   lane_write_en_n;
   logic               byte_write_permit_n;
   logic               full_word_write_n;
   logic               out_enable_n;
   logic               snooze_in;
   logic               burst_linear;
   logic [LANES*8-1:0] mst_data;
   logic [LANES-1:0]   mst_parity;
   logic               mst_drive;
   logic [LANES*8-1:0] dev_data;
   logic [LANES-1:0]   dev_parity;
   logic               dev_drive;
   logic [LANES*8-1:0] data_lanes;
   logic [LANES-1:0]   parity_lanes;

   // ------------------------------------------------------------------------
   // Shared data wires resolved from the two drive enables
   // ------------------------------------------------------------------------
   assign data_lanes   = dev_drive ? dev_data
                       : (mst_drive ? mst_data : '0);
   assign parity_lanes = dev_drive ? dev_parity
                       : (mst_drive ? mst_parity : '0);

   modport device (
      input  addr, addr_strobe_proc_n, addr_strobe_ctrl_n, burst_advance_n,
      input  chip_sel_n, chip_sel_expand_hi, chip_sel_expand_n,
      input  lane_write_en_n, byte_write_permit_n, full_word_write_n,
      input  out_enable_n, snooze_in, burst_linear,
      input  data_lanes, parity_lanes,
      output dev_data, dev_parity, dev_drive
   );

   modport master (
      output addr, addr_strobe_proc_n, addr_strobe_ctrl_n, burst_advance_n,
      output chip_sel_n, chip_sel_expand_hi, chip_sel_expand_n,
      output lane_write_en_n, byte_write_permit_n, full_word_write_n,
      output out_enable_n, snooze_in, burst_linear,
      output mst_data, mst_parity, mst_drive,
      input  data_lanes, parity_lanes
   );
endinterface

/* File: burst_addr_gen.sv */
// Two-bit burst counter producing the low address bits of each beat
`timescale 1ns/10ps
`include "sram_port_defines.svh"
module burst_addr_gen (
   input  wire logic                      ref_clk,
   input  wire logic                      resetn,
   input  wire logic                      load,
   input  wire logic                      advance,
   input  wire logic                      linear,
   input  wire logic [`BURST_LO_BITS-1:0] start_lo,
   output logic      [`BURST_LO_BITS-1:0] cur_lo
);
   import sram_port_pkg::*;

   logic [`BURST_LO_BITS-1:0] start_reg;
   logic [`BURST_LO_BITS-1:0] start_next;
   logic [`BURST_LO_BITS-1:0] beat_reg;
   logic [`BURST_LO_BITS-1:0] beat_next;

   // ------------------------------------------------------------------------
   // Beat count and sequence
   // ------------------------------------------------------------------------
   always_comb begin
      start_next = load ? start_lo : start_reg;
      beat_next  = beat_reg;
      if (load) begin
         beat_next = '0;
      end else if (advance) begin
         beat_next = beat_reg + 2'h1; // R3 R8
      end
      if (linear) begin
         cur_lo = start_next + beat_next; // R6 R21
      end else begin
         cur_lo = start_next ^ beat_next; // R6 R21
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         start_reg <= '0;
         beat_reg  <= '0;
      end else begin
         start_reg <= start_next;
         beat_reg  <= beat_next;
      end
   end
endmodule // burst_addr_gen

/* File: sram_master.sv */
// Bus master end: issues single or four-beat bursts to the memory
`timescale 1ns/10ps
`include "sram_port_defines.svh"
module sram_master #(
   parameter int ADDR_W = `ADDR_W_WIDE,
   parameter int LANES  = `LANES_WIDE
) (
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   sram_bus_if.master                bus,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire logic                 cmd_write,
   input  wire logic                 cmd_burst,
   input  wire logic [ADDR_W-1:0]    cmd_addr,
   input  wire logic [LANES-1:0]     cmd_lanes,
   input  wire logic [LANES*8-1:0]   wr_data,
   input  wire logic [LANES-1:0]     wr_parity,
   output logic                      wr_take,
   output logic                      rd_valid,
   output logic [LANES*8-1:0]        rd_data,
   output logic [LANES-1:0]          rd_parity,
   input  wire logic                 linear_order,
   input  wire logic                 snooze_req
);
   import sram_port_pkg::*;

   if (LANES != `LANES_X18 && LANES != `LANES_WIDE) begin
      $error("sram_master: LANES must be 2 or 4");
   end

   localparam ctrl_pins_t IDLE_PINS = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                        1'b1, 1'b1, 1'b1, 1'b1};

   mst_state_t                st_reg, st_next;
   ctrl_pins_t                pins_reg, pins_next;
   logic [ADDR_W-1:0]         addr_reg, addr_next;
   logic [LANES-1:0]          lane_n_reg, lane_n_next;
   logic [LANES*8-1:0]        dout_reg, dout_next;
   logic [LANES-1:0]          pout_reg, pout_next;
   logic                      drive_reg, drive_next;
   logic                      wr_reg, wr_next;
   logic [1:0]                left_reg, left_next;
   logic [`READ_LATENCY-1:0]  rd_pipe_reg, rd_pipe_next;
   logic                      rdv_reg, rdv_next;
   logic [LANES*8-1:0]        rdd_reg, rdd_next;
   logic [LANES-1:0]          rdp_reg, rdp_next;
   logic                      beat_rd;

   // ------------------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------------------
   always_comb begin
      cmd_ready   = (st_reg == M_IDLE) && (rd_pipe_reg == '0);
      st_next     = st_reg;
      pins_next   = IDLE_PINS;
      addr_next   = addr_reg;
      lane_n_next = '1;
      dout_next   = dout_reg;
      pout_next   = pout_reg;
      drive_next  = 1'b0;
      wr_next     = wr_reg;
      left_next   = left_reg;
      wr_take     = 1'b0;
      case (st_reg)
         M_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               wr_next   = cmd_write;
               addr_next = cmd_addr;
               left_next = cmd_burst ? 2'(`BURST_BEATS - 1) : 2'h0;
               pins_next.addr_strobe_ctrl_n = 1'b0; // R7
               pins_next.chip_sel_n         = 1'b0; // R4
               pins_next.chip_sel_expand_hi = 1'b1;
               pins_next.chip_sel_expand_n  = 1'b0;
               st_next = cmd_burst ? M_BURST : M_DESEL;
            end
         end
         M_BURST: begin
            pins_next.burst_advance_n = 1'b0; // R8
            left_next = left_reg - 2'h1;
            if (left_reg == 2'h1) begin
               st_next = M_DESEL;
            end
         end
         M_DESEL: begin
            pins_next.addr_strobe_ctrl_n = 1'b0;
            st_next = M_IDLE;
         end
         default: st_next = M_IDLE;
      endcase
      if (st_next != M_IDLE && wr_next) begin
         wr_take    = 1'b1;
         dout_next  = wr_data;
         pout_next  = wr_parity;
         drive_next = 1'b1;
         if (cmd_lanes == '1) begin
            pins_next.full_word_write_n = 1'b0; // R12
         end else begin
            pins_next.byte_write_permit_n = 1'b0; // R19
            lane_n_next = ~cmd_lanes; // R19
         end
      end
      // A read beat is on the pins at every selecting load and every advance
      beat_rd      = (st_reg != M_IDLE) && !wr_reg
                     && (!pins_reg.chip_sel_n
                         || !pins_reg.burst_advance_n); // R8 R22
      rd_pipe_next = {rd_pipe_reg[0], beat_rd};
      pins_next.out_enable_n = !((st_next != M_IDLE && !wr_next)
                               || (rd_pipe_next != '0));
      rdv_next = rd_pipe_reg[`READ_LATENCY-1]; // R22
      rdd_next = rdv_next ? bus.data_lanes : rdd_reg;
      rdp_next = rdv_next ? bus.parity_lanes : rdp_reg;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg      <= M_IDLE;
         pins_reg    <= IDLE_PINS;
         addr_reg    <= '0;
         lane_n_reg  <= '1;
         dout_reg    <= '0;
         pout_reg    <= '0;
         drive_reg   <= 1'b0;
         wr_reg      <= 1'b0;
         left_reg    <= '0;
         rd_pipe_reg <= '0;
         rdv_reg     <= 1'b0;
         rdd_reg     <= '0;
         rdp_reg     <= '0;
      end else begin
         st_reg      <= st_next;
         pins_reg    <= pins_next;
         addr_reg    <= addr_next;
         lane_n_reg  <= lane_n_next;
         dout_reg    <= dout_next;
         pout_reg    <= pout_next;
         drive_reg   <= drive_next;
         wr_reg      <= wr_next;
         left_reg    <= left_next;
         rd_pipe_reg <= rd_pipe_next;
         rdv_reg     <= rdv_next;
         rdd_reg     <= rdd_next;
         rdp_reg     <= rdp_next;
      end
   end

   // ------------------------------------------------------------------------
   // Pin outputs, all from flip-flops except the static inputs
   // ------------------------------------------------------------------------
   assign bus.addr                = addr_reg; // R1
   assign bus.addr_strobe_proc_n  = pins_reg.addr_strobe_proc_n;
   assign bus.addr_strobe_ctrl_n  = pins_reg.addr_strobe_ctrl_n;
   assign bus.burst_advance_n     = pins_reg.burst_advance_n;
   assign bus.chip_sel_n          = pins_reg.chip_sel_n;
   assign bus.chip_sel_expand_hi  = pins_reg.chip_sel_expand_hi;
   assign bus.chip_sel_expand_n   = pins_reg.chip_sel_expand_n;
   assign bus.byte_write_permit_n = pins_reg.byte_write_permit_n;
   assign bus.full_word_write_n   = pins_reg.full_word_write_n;
   assign bus.out_enable_n        = pins_reg.out_enable_n;
   assign bus.lane_write_en_n     = lane_n_reg;
   assign bus.mst_data            = dout_reg;
   assign bus.mst_parity          = pout_reg;
   assign bus.mst_drive           = drive_reg;
   assign bus.burst_linear        = linear_order;
   assign bus.snooze_in           = snooze_req;
   assign rd_valid                = rdv_reg;
   assign rd_data                 = rdd_reg;
   assign rd_parity               = rdp_reg;
endmodule // sram_master

/* File: sram_port_props.sv */
// Pin-level timing checks for the burst memory port
`timescale 1ns/10ps
module sram_port_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic addr_strobe_ctrl_n,
   input wire logic burst_advance_n,
   input wire logic chip_sel_n,
   input wire logic chip_sel_expand_hi,
   input wire logic chip_sel_expand_n,
   input wire logic byte_write_permit_n,
   input wire logic full_word_write_n,
   input wire logic out_enable_n,
   input wire logic snooze_in,
   input wire logic mst_drive,
   input wire logic dev_drive
);
   logic ld;
   logic rd_ld;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   assign ld = !addr_strobe_ctrl_n;
   assign rd_ld = ld && !chip_sel_n && full_word_write_n
                  && byte_write_permit_n;
   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   a_drive_needs_oe: assert property (dev_drive |-> !out_enable_n)
      else $error("device drives with output enable off");
   a_snooze_floats: assert property (snooze_in |-> !dev_drive)
      else $error("device drives during snooze");
   a_read_drives: assert property
      (rd_ld ##2 !(out_enable_n || snooze_in) |-> dev_drive)
      else $error("read data not driven");
   a_single_deselect: assert property
      (ld && chip_sel_n |-> ##2 !dev_drive)
      else $error("bus not floated after deselect");
   a_no_bus_clash: assert property (!(dev_drive && mst_drive))
      else $error("both ends drive the data bus");
   a_select_all: assert property
      (ld && !chip_sel_n |-> chip_sel_expand_hi && !chip_sel_expand_n)
      else $error("expansion enables not asserted");
   a_write_ctrl: assert property
      (ld && mst_drive |-> !(full_word_write_n && byte_write_permit_n))
      else $error("write without write controls");
   a_burst_beats: assert property
      ($fell(burst_advance_n) |-> !burst_advance_n[*3] ##1 burst_advance_n)
      else $error("burst advance length wrong");
   c_read: cover property (rd_ld);
   c_burst: cover property ($fell(burst_advance_n));
   c_snooze: cover property (snooze_in);
endmodule // sram_port_props

/* File: tb.sv */
// Self-checking bench for the burst memory port, both ends
`timescale 1ns/10ps
module tb;
   import sram_port_pkg::*;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cmd_valid = 1'b0;
   logic        cmd_write = 1'b0;
   logic        cmd_burst = 1'b0;
   logic        linear_order = 1'b0;
   logic        snooze_req = 1'b0;
   logic        cmd_ready, wr_take, rd_valid, standby;
   logic [15:0] cmd_addr = 16'h0000;
   logic [3:0]  cmd_lanes = 4'h0;
   logic [3:0]  wr_parity = 4'h0;
   logic [3:0]  rd_parity;
   logic [31:0] wr_data = 32'h0000_0000;
   logic [31:0] rd_data;
   logic [35:0] rd_q[$];
   int          bad_count = 0;
   int          checks_done = 0;
   sram_bus_if #(.ADDR_W(16), .LANES(4)) bus ();
   sram_device sram_device_i (.*);
   sram_master sram_master_i (.*);
   sram_port_props sram_port_props_i (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .addr_strobe_ctrl_n(bus.addr_strobe_ctrl_n),
      .burst_advance_n(bus.burst_advance_n),
      .chip_sel_n(bus.chip_sel_n),
      .chip_sel_expand_hi(bus.chip_sel_expand_hi),
      .chip_sel_expand_n(bus.chip_sel_expand_n),
      .byte_write_permit_n(bus.byte_write_permit_n),
      .full_word_write_n(bus.full_word_write_n),
      .out_enable_n(bus.out_enable_n),
      .snooze_in(bus.snooze_in),
      .mst_drive(bus.mst_drive),
      .dev_drive(bus.dev_drive)
   );
   // ---------------------------------------------------------------------
   // Clock, write data stepping and read capture
   // ---------------------------------------------------------------------
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (wr_take === 1'b1)
         wr_data <= wr_data + 32'h0101_0101;
      if (rd_valid === 1'b1)
         rd_q.push_back({rd_parity, rd_data});
   end
   task automatic chk(input string nm, input logic [35:0] e, g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Issue one command, then wait until the master is free again
   task automatic cmd(input logic w, b, input logic [15:0] a,
                      input logic [3:0] ln, p, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_burst <= b;
      cmd_addr <= a;
      cmd_lanes <= ln;
      wr_parity <= p;
      wr_data <= d;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 99) begin
         @(negedge ref_clk);
         n++;
      end
      chk("cmd_ready", 36'h1, {35'd0, cmd_ready});
   endtask
   // Last read word is pushed at the edge after the master frees up
   task automatic rd(input logic b, input logic [15:0] a);
      rd_q.delete();
      cmd(1'b0, b, a, 4'h0, 4'h0, 32'h0000_0000);
      @(negedge ref_clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      cmd(1'b1, 1'b0, 16'h0020, 4'hf, 4'hf, 32'haabb_ccdd);
      cmd(1'b1, 1'b0, 16'h0020, 4'h5, 4'h0, 32'h1122_3344);
      rd(1'b0, 16'h0020);
      chk("lane merge", 36'ha_aa22_cc44, rd_q[0]);
      @(posedge ref_clk);
      linear_order <= 1'b1;
      cmd(1'b1, 1'b1, 16'h0011, 4'hf, 4'h3, 32'h1000_0000);
      @(posedge ref_clk);
      linear_order <= 1'b0;
      for (int s = 0; s < 4; s += 3) begin
         rd(1'b1, 16'h0010 | 16'(s));
         for (int i = 0; i < 4; i++)
            chk("burst", {4'h3, 32'h1000_0000 + 32'h0101_0101 *
                32'(((s ^ i) - 1) & 3)}, rd_q[i]);
      end
      @(posedge ref_clk);
      snooze_req <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("standby", 36'h0_0000_0001, {35'd0, standby});
      snooze_req <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("wake", 36'h0_0000_0000, {35'd0, standby});
      end_of_test();
   end
   // Tests need under a hundred cycles; 4000 cycles means a hang
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
endmodule // tb
